// >>> design/dual_host_control.sv
// Dual-host control arbitration, status reporting, alerts and LEDs
`timescale 1ns/100ps

// Function
// - Input LED, two-wire mode only: steady ok, blink out of limits
// - Service LED steady on overtemperature warning
// - Position addresses used only in RS485 mode
// - Bus 1 out of turn: alert 1, C1
// - Bus 0 out of turn rejected: alert 0, 1C
// - Only controlling bus changes operating state
// - Unit fault under bus 0: both alerts, word
// - Takeover: both alerts, 74 or 47
// - Clear drops own alert, and the other alert if that bus status is idle
// - Bad command bus 1: alert, 0002, 80
// - Isolation test result latched until clear
// - Output shutdown latched until clear
// - All faults latched until clear; overtemperature warning follows its pin
// - Response settings change only by command
// - Persisting fault relatches after clear
// - Operational state indications follow live state
// - No restarted-successfully bit exists
// - Alerts active low, open drain
module dual_host_control
  import host_ctl_pkg::*;
#(
  parameter int BLINK_COUNT = BLINK_CYCLES
) (
  input  wire logic                clock,          // 100 MHz clock
  input  wire logic                srst,           // Sync reset, high
  input  wire logic [1:0]          comm_mode,      // comm_mode_type
  input  wire logic [1:0]          cmd_valid,      // Command pulse per bus
  input  wire logic [1:0]          cmd_bad,        // Command is invalid
  input  wire logic [1:0]          cmd_clear,      // Clear-faults pulse
  input  wire logic [1:0]          cmd_takeover,   // Takeover request
  input  wire logic [1:0]          cmd_set_resp,   // Write response setting
  input  wire logic [7:0]          cmd_resp_data,  // Setting value, shared by both buses
  input  wire logic                cmd_on,         // Output on command value
  input  wire logic [FAULT_W-1:0]  fault_raw,      // Live fault pin levels
  input  wire logic                input_ok_raw,   // Input acceptable pin
  input  wire logic                input_pres_raw, // Input present pin
  input  wire logic                overtemp_warning_n, // Pin, low is warning
  input  wire logic [3:0]          rack_position_address, // Pin group
  input  wire logic [3:0]          cabinet_row_address,   // Pin group
  output logic                     alert_n_out_0,  // Alert 0, always low
  output logic                     alert_n_oe_0,   // Alert 0 pulls low
  output logic                     alert_n_out_1,  // Alert 1, always low
  output logic                     alert_n_oe_1,   // Alert 1 pulls low
  output logic                     in_control,     // Bus holding control
  output logic [7:0]               status_bus,     // Bus status value
  output logic [15:0]              status_word,    // Word status value
  output logic [7:0]               status_cml,     // Comm status value
  output logic [FAULT_W-1:0]       fault_latched,  // Sticky fault bits
  output logic                     fault_live,     // Any fault now
  output logic                     output_on,      // Operating state
  output logic [7:0]               resp_setting,   // Response settings
  output logic [7:0]               station_address, // Used address
  output logic                     led_input,      // Input LED
  output logic                     led_service     // Service LED
);

  typedef struct packed {
    logic [FAULT_W-1:0] flt_s1;
    logic [FAULT_W-1:0] flt_s2;
    logic               iok_s1, iok_s2, ipr_s1, ipr_s2, otw_s1, otw_s2;
    logic [7:0]         addr_s1, addr_s2;
    logic               ctl;
    logic [1:0]         alert;
    logic [3:0]         nib0, nib1;
    logic               word_evt;
    logic               cml_evt;
    logic [FAULT_W-1:0] latched;
    logic               on;
    logic [7:0]         resp;
    logic [BLINK_W-1:0] blink_cnt;
    logic               blink;
    logic               led_in, led_svc;
    logic [7:0]         addr_out;
    logic [15:0]        word;
    logic [7:0]         cml;
    logic               live;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  function automatic logic [3:0] idle_nib(input logic side, input logic ctl);
    idle_nib = (side == ctl) ? NIB_IDLE_LO : 4'h0;
  endfunction : idle_nib

  always_comb begin
    st_nxt = st_r;
    st_nxt.flt_s1  = fault_raw;
    st_nxt.flt_s2  = st_r.flt_s1;
    st_nxt.iok_s1  = input_ok_raw;
    st_nxt.iok_s2  = st_r.iok_s1;
    st_nxt.ipr_s1  = input_pres_raw;
    st_nxt.ipr_s2  = st_r.ipr_s1;
    st_nxt.otw_s1  = overtemp_warning_n;
    st_nxt.otw_s2  = st_r.otw_s1;
    st_nxt.addr_s1 = {cabinet_row_address, rack_position_address};
    st_nxt.addr_s2 = st_r.addr_s1;

    // Common blink source, used by the input LED only
    if (st_r.blink_cnt >= BLINK_W'(BLINK_COUNT - 1)) begin
      st_nxt.blink_cnt = '0;
      st_nxt.blink     = ~st_r.blink;
    end else begin
      st_nxt.blink_cnt = st_r.blink_cnt + BLINK_W'(1);
    end

    // Clear first so a fresh event in the same cycle wins
    // Other alert drops only when its own bus status is idle
    if (cmd_clear[0]) begin
      st_nxt.alert[0] = 1'b0;
      st_nxt.nib0     = idle_nib(1'b0, st_r.ctl);
      if (st_r.nib1 == idle_nib(1'b1, st_r.ctl)) begin
        st_nxt.alert[1] = 1'b0;
      end
    end
    if (cmd_clear[1]) begin
      st_nxt.alert[1] = 1'b0;
      st_nxt.nib1     = idle_nib(1'b1, st_r.ctl);
      if (st_r.nib0 == idle_nib(1'b0, st_r.ctl)) begin
        st_nxt.alert[0] = 1'b0;
      end
    end
    if (|cmd_clear) begin
      // Live faults set again below
      st_nxt.latched  = '0;
      st_nxt.word_evt = 1'b0;
      st_nxt.cml_evt  = 1'b0;
    end

    // Commands from the non-controlling bus are refused
    if (cmd_valid[1] && !st_r.ctl && !cmd_takeover[1]) begin
      st_nxt.alert[1] = 1'b1;
      st_nxt.nib1     = 4'hC;
    end
    if (cmd_valid[0] && st_r.ctl && !cmd_takeover[0]) begin
      st_nxt.alert[0] = 1'b1;
      st_nxt.nib0     = 4'hC;
    end

    // Takeover: new owner nibble 7, old owner nibble 4
    if (cmd_takeover[1] && !st_r.ctl) begin
      st_nxt.ctl   = 1'b1;
      st_nxt.alert = 2'b11;
      st_nxt.nib1  = 4'h7;
      st_nxt.nib0  = 4'h4;
    end else if (cmd_takeover[0] && st_r.ctl) begin
      st_nxt.ctl   = 1'b0;
      st_nxt.alert = 2'b11;
      st_nxt.nib0  = 4'h7;
      st_nxt.nib1  = 4'h4;
    end

    // Operating state and settings only from the owner
    if (cmd_valid[st_r.ctl] && !cmd_bad[st_r.ctl]) begin
      st_nxt.on = cmd_on;
    end
    if (cmd_set_resp[st_r.ctl]) begin
      st_nxt.resp = cmd_resp_data;
    end

    // Bad command from either bus
    for (int b = 0; b < 2; b++) begin
      if (cmd_valid[b] && cmd_bad[b]) begin
        st_nxt.alert[b] = 1'b1;
        st_nxt.cml_evt  = 1'b1;
      end
    end

    // Faults latch and re-latch while still present
    // Compared after the clear so a persisting fault alerts again
    if (|(st_r.flt_s2 & ~st_nxt.latched)) begin
      st_nxt.alert = 2'b11;
    end
    st_nxt.latched = st_nxt.latched | st_r.flt_s2;

    // Input LED only in two-wire mode
    if (comm_mode_type'(comm_mode) == MODE_TWO_WIRE) begin
      st_nxt.led_in = st_r.iok_s2 | (st_r.ipr_s2 & st_r.blink);
    end else begin
      st_nxt.led_in = 1'b0;
    end
    st_nxt.led_svc = ~st_r.otw_s2;

    if (comm_mode_type'(comm_mode) == MODE_RS485) begin
      st_nxt.addr_out = st_r.addr_s2;
    end else begin
      st_nxt.addr_out = 8'h00;
    end

    // Status words built from next state so outputs stay registered
    if (st_nxt.cml_evt) begin
      st_nxt.word = WORD_BAD_CMD;
    end else if (|st_nxt.latched) begin
      st_nxt.word = {8'h00, st_nxt.latched};
    end else begin
      st_nxt.word = WORD_CLEAR;
    end
    st_nxt.cml  = st_nxt.cml_evt ? CML_BAD_CMD : CML_CLEAR;
    st_nxt.live = |st_r.flt_s2;

    if (srst) begin
      st_nxt = '0;
      st_nxt.nib0 = NIB_IDLE_LO;
    end
  end

  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end

  // Open-drain alerts: drive low only when asserted
  assign alert_n_out_0 = 1'b0;
  assign alert_n_out_1 = 1'b0;
  assign alert_n_oe_0  = st_r.alert[0];
  assign alert_n_oe_1  = st_r.alert[1];
  assign in_control    = st_r.ctl;
  assign status_bus    = {st_r.nib1, st_r.nib0};
  // No restart bit; word reports bad command first, else latched fault states
  assign status_word   = st_r.word;
  assign status_cml    = st_r.cml;
  assign fault_latched = st_r.latched;
  assign fault_live    = st_r.live;
  assign output_on     = st_r.on;
  assign resp_setting  = st_r.resp;
  assign station_address = st_r.addr_out;
  assign led_input     = st_r.led_in;
  assign led_service   = st_r.led_svc;

endmodule : dual_host_control

// >>> design/host_ctl_pkg.sv
// Constants for the dual-host control and fault report block
package host_ctl_pkg;
  localparam logic [7:0]  BUS_IDLE_0     = 8'h01; // Bus 0 in control, quiet
  localparam logic [7:0]  BUS_IDLE_1     = 8'h10; // Bus 1 in control, quiet
  localparam logic [7:0]  BUS_REJ_1      = 8'hC1; // Bus 1 spoke out of turn
  localparam logic [7:0]  BUS_REJ_0      = 8'h1C; // Bus 0 spoke out of turn
  localparam logic [7:0]  BUS_TAKE_1     = 8'h74; // Bus 1 took over
  localparam logic [7:0]  BUS_TAKE_0     = 8'h47; // Bus 0 took over
  localparam logic [3:0]  NIB_IDLE_LO    = 4'h1;  // Quiet nibble, controlling bus side
  localparam logic [15:0] WORD_CLEAR     = 16'h0000;
  localparam logic [15:0] WORD_BAD_CMD   = 16'h0002;
  localparam logic [7:0]  CML_CLEAR      = 8'h00;
  localparam logic [7:0]  CML_BAD_CMD    = 8'h80;
  localparam int          FAULT_W        = 8;     // Fault source count
  localparam int          BLINK_HALF_MS  = 250;   // Blink half period, ms
  localparam int          CLK_KHZ        = 100000;
  localparam int          BLINK_CYCLES   = BLINK_HALF_MS * CLK_KHZ;
  localparam int          BLINK_W        = 25;

  typedef enum logic [1:0] {
    MODE_ANALOG = 2'b00,
    MODE_TWO_WIRE = 2'b01,
    MODE_RS485 = 2'b10
  } comm_mode_type;
endpackage : host_ctl_pkg

// >>> testbench/dual_host_props.sv
// Port assertions for the dual-host control block
`timescale 1ns/100ps
module dual_host_props
  import host_ctl_pkg::*;
(
  input wire logic               clock,           // Clock
  input wire logic               srst,            // Reset
  input wire logic [1:0]         comm_mode,       // Mode
  input wire logic [1:0]         cmd_valid,       // Command
  input wire logic [1:0]         cmd_bad,         // Invalid
  input wire logic [1:0]         cmd_clear,       // Clear
  input wire logic [1:0]         cmd_takeover,    // Takeover
  input wire logic               alert_n_out_0,   // Level
  input wire logic               alert_n_out_1,   // Level
  input wire logic               alert_n_oe_0,    // Drive
  input wire logic               alert_n_oe_1,    // Drive
  input wire logic               in_control,      // Owner
  input wire logic [7:0]         status_bus,      // Bus status
  input wire logic [15:0]        status_word,     // Word status
  input wire logic [7:0]         status_cml,      // Comm status
  input wire logic [FAULT_W-1:0] fault_latched,   // Sticky
  input wire logic [7:0]         station_address, // Address
  input wire logic               overtemp_warning_n, // Warning pin
  input wire logic               led_input,       // Input LED
  input wire logic               led_service      // Service LED
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_take_1;
    cmd_takeover == 2'b10 && !in_control && cmd_clear == 2'b00;
  endsequence
  sequence s_take_0;
    cmd_takeover == 2'b01 && in_control && cmd_clear == 2'b00;
  endsequence
  sequence s_both_up;
    alert_n_oe_0 && alert_n_oe_1;
  endsequence
  a_take_one: assert property (
    s_take_1 |=> s_both_up ##0 (status_bus == BUS_TAKE_1 && in_control))
    else $error("takeover by bus 1 misreported");
  a_take_zero: assert property (
    s_take_0 |=> s_both_up ##0 (status_bus == BUS_TAKE_0 && !in_control))
    else $error("takeover by bus 0 misreported");
  a_reject_one: assert property (
    cmd_valid == 2'b10 && !in_control
      && (cmd_bad | cmd_clear | cmd_takeover) == 2'b00
    |=> alert_n_oe_1 && status_bus[7:4] == 4'hC)
    else $error("bus 1 out of turn not flagged");
  a_reject_zero: assert property (
    cmd_valid == 2'b01 && in_control
      && (cmd_bad | cmd_clear | cmd_takeover) == 2'b00
    |=> alert_n_oe_0 && status_bus[3:0] == 4'hC)
    else $error("bus 0 out of turn not flagged");
  a_bad_cmd: assert property (
    cmd_valid[1] && cmd_bad[1] && in_control && cmd_clear == 2'b00
    |=> alert_n_oe_1 && status_word == WORD_BAD_CMD
      && status_cml == CML_BAD_CMD)
    else $error("bad command on bus 1 misreported");
  a_drive_low: assert property (
    alert_n_out_0 == 1'b0 && alert_n_out_1 == 1'b0)
    else $error("alert pin driven high");
  a_fault_sticky: assert property (
    cmd_clear == 2'b00 |=> (fault_latched & $past(fault_latched))
      == $past(fault_latched))
    else $error("latched fault lost without clear");
  a_addr_off: assert property (
    comm_mode != MODE_RS485 [*5] |-> station_address == 8'h00)
    else $error("address used outside serial mode");
  a_svc_led_on: assert property (
    !overtemp_warning_n [*4] |-> led_service)
    else $error("service LED off during warning");
  a_input_led_off: assert property (
    comm_mode != MODE_TWO_WIRE [*2] |-> !led_input)
    else $error("input LED lit outside two-wire mode");
endmodule : dual_host_props

bind dual_host_control dual_host_props props_i (.*);

// >>> testbench/host_pair.sv
// Two management hosts issuing commands to the block
`timescale 1ns/100ps
module host_pair (
  input  wire logic [7:0] status_bus,   // Status read by hosts
  input  wire logic       clock,        // Block clock
  output logic      [1:0] cmd_valid,    // Command
  output logic      [1:0] cmd_bad,      // Invalid
  output logic      [1:0] cmd_clear,    // Clear-faults
  output logic      [1:0] cmd_takeover, // Takeover
  output logic      [1:0] cmd_set_resp  // Setting write
);
  logic [7:0] read_status_r;
  initial {cmd_valid, cmd_bad, cmd_clear, cmd_takeover, cmd_set_resp} = '0;
  // Op: 0 command, 1 bad, 2 clear, 3 takeover, 4 setting write
  task automatic send(input int b, input int op);
    @(negedge clock);
    if (op == 2) read_status_r = status_bus; // Read before clear
    cmd_valid[b]    = (op == 0 || op == 1 || op == 4);
    cmd_bad[b]      = (op == 1);
    cmd_clear[b]    = (op == 2);
    cmd_takeover[b] = (op == 3);
    cmd_set_resp[b] = (op == 4);
    @(negedge clock);
    {cmd_valid, cmd_bad, cmd_clear, cmd_takeover, cmd_set_resp} = '0;
  endtask : send
endmodule : host_pair

// >>> testbench/tb_top.sv
// Self-checking bench for the dual-host control block
`timescale 1ns/100ps
module tb_top;
  import host_ctl_pkg::*;
  typedef struct packed {logic [1:0] sel; logic [33:0] val;} note_type;
  logic        clock, srst, cmd_on, input_ok_raw, input_pres_raw;
  logic        overtemp_warning_n, alert_n_out_0, alert_n_oe_0, fault_live;
  logic        alert_n_out_1, alert_n_oe_1, in_control, output_on;
  logic        led_input, led_service;
  logic [1:0]  comm_mode, cmd_valid, cmd_bad, cmd_clear, cmd_takeover;
  logic [1:0]  cmd_set_resp;
  logic [3:0]  rack_position_address, cabinet_row_address;
  logic [7:0]  cmd_resp_data, fault_raw, fault_latched, status_bus, r, f;
  logic [7:0]  status_cml, resp_setting, station_address;
  logic [15:0] status_word;
  int          error_cnt = 0;
  int          n_checks = 0;
  note_type    notes[$];
  dual_host_control #(.BLINK_COUNT(4)) dual_host_control_i (.*);
  host_pair host_pair_i (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [33:0] st(logic [7:0] b, logic [1:0] oe,
      logic [15:0] w = WORD_CLEAR, logic [7:0] c = CML_CLEAR);
    return {b, w, c, oe};
  endfunction : st
  function automatic logic [33:0] seen(logic [1:0] s);
    case (s)
      2'd0: return st(status_bus, {alert_n_oe_1, alert_n_oe_0},
                      status_word, status_cml);
      2'd1: return {16'h0000, alert_n_oe_1, alert_n_oe_0, status_bus,
                    fault_latched};
      2'd2: return {25'h0000000, output_on, resp_setting};
      default: return {26'h0000000, station_address};
    endcase
  endfunction : seen
  task automatic check(string what, logic [33:0] got, logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic step(int b, int op, logic [33:0] e);
    host_pair_i.send(b, op);
    notes.push_back({2'd0, e});
  endtask : step
  task automatic later(logic [1:0] s, logic [33:0] e, int n);
    repeat (n) @(negedge clock);
    notes.push_back({s, e});
  endtask : later
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // Oldest note meets the outputs once its result has landed
  always @(negedge clock) begin : watch
    note_type n;
    if (notes.size() != 0) begin
      n = notes.pop_front();
      check("outputs", seen(n.sel), n.val);
    end
  end
  initial begin
    void'($urandom(32'h6f75));
    {input_ok_raw, input_pres_raw, overtemp_warning_n, srst} = 4'hF;
    {cmd_on, cmd_resp_data, fault_raw, rack_position_address} = '0;
    cabinet_row_address = 4'h0;
    comm_mode = MODE_TWO_WIRE;
    repeat (5) @(negedge clock);
    srst = 1'b0;
    step(1, 0, st(BUS_REJ_1, 2'b10));
    step(1, 2, st(BUS_IDLE_0, 2'b00));
    f = 8'($urandom_range(255, 1));
    fault_raw = f;
    repeat (4) @(negedge clock);
    fault_raw = 8'h00;
    later(2'd1, {16'h0000, 2'b11, BUS_IDLE_0, f}, 4);
    step(0, 2, st(BUS_IDLE_0, 2'b00));
    fault_raw = f;
    repeat (4) @(negedge clock);
    host_pair_i.send(0, 2);
    later(2'd1, {16'h0000, 2'b11, BUS_IDLE_0, f}, 3);
    fault_raw = 8'h00;
    repeat (4) @(negedge clock);
    step(0, 2, st(BUS_IDLE_0, 2'b00));
    step(1, 3, st(BUS_TAKE_1, 2'b11));
    step(1, 2, st(8'h14, 2'b01));
    step(0, 2, st(BUS_IDLE_1, 2'b00));
    r = 8'($urandom);
    {cmd_on, cmd_resp_data} = {r[0], r};
    step(1, 0, st(BUS_IDLE_1, 2'b00));
    step(1, 4, st(BUS_IDLE_1, 2'b00));
    later(2'd2, {25'h0000000, r[0], r}, 0);
    {cmd_on, cmd_resp_data} = {~r[0], ~r};
    step(0, 4, st(BUS_REJ_0, 2'b01));
    later(2'd2, {25'h0000000, r[0], r}, 0);
    step(0, 2, st(BUS_IDLE_1, 2'b00));
    later(2'd2, {25'h0000000, r[0], r}, 0);
    step(1, 1, st(BUS_IDLE_1, 2'b10, WORD_BAD_CMD, CML_BAD_CMD));
    step(1, 2, st(BUS_IDLE_1, 2'b00));
    step(0, 3, st(BUS_TAKE_0, 2'b11));
    step(0, 2, st(8'h41, 2'b10));
    step(1, 2, st(BUS_IDLE_0, 2'b00));
    r = 8'($urandom);
    {cabinet_row_address, rack_position_address} = r;
    comm_mode = MODE_RS485;
    later(2'd3, {26'h0000000, r}, 5);
    comm_mode = MODE_ANALOG;
    later(2'd3, 34'h000000000, 5);
    overtemp_warning_n = 1'b0;
    fault_raw = 8'h01;
    repeat (5) @(negedge clock);
    check("service led", led_service, 34'h1);
    check("live fault", fault_live, 34'h1);
    check("input led off", led_input, 34'h0);
    comm_mode = MODE_TWO_WIRE;
    repeat (5) @(negedge clock);
    check("input led on", led_input, 34'h1);
    input_ok_raw = 1'b0;
    repeat (5) @(negedge clock);
    f = {7'h00, led_input};
    repeat (4) @(negedge clock);
    check("input led blink", led_input, {33'h0, ~f[0]});
    for (int i = 0; i < 20 && notes.size() != 0; i++) @(negedge clock);
    if (notes.size() != 0) error_cnt++;
    stop_test();
  end
endmodule : tb_top
